// ### include/frf_pkg.sv
/*
 * Shared constants and types of the floppy rate, data port and result status slice.
 * Assumes a 25 MHz bus clock and a 32-bit AHB-Lite register bus; one register per word.
 */
package frf_pkg;

    // Register indices; the byte address of each register is four times its index.
    localparam int unsigned RATE_CTRL_INDEX = 4;
    localparam int unsigned DATA_PORT_INDEX = 5;
    localparam int unsigned IRQ_STATUS_INDEX = 8;
    localparam int unsigned IRQ_MASK_INDEX = 9;

    // Field positions of the rate and control register.
    localparam int unsigned SOFT_RESET_BIT = 7;
    localparam int unsigned LOW_POWER_BIT = 6;
    localparam int unsigned SHIFT_LSB = 2;
    localparam int unsigned RATE_LSB = 0;

    // Reset values of the rate and control fields.
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [2:0] SHIFT_RESET = 3'h0;
    localparam logic LOW_POWER_RESET = 1'b0;

    // Write-shift and rate codes with a special meaning.
    localparam logic [2:0] SHIFT_DEFAULT_CODE = 3'h0;
    localparam logic [2:0] SHIFT_OFF_CODE = 3'h7;
    localparam logic [1:0] RATE_TOP_CODE = 2'h3;

    // Interrupt status bit positions and width.
    localparam int unsigned IRQ_RESULT_BIT = 0;
    localparam int unsigned IRQ_BAD_RATE_BIT = 1;
    localparam int unsigned IRQ_RESET_DONE_BIT = 2;
    localparam int unsigned IRQ_WIDTH = 3;

    // Timing: clock period and the length of a software reset.
    localparam int unsigned CLOCK_PERIOD_NS = 40;
    localparam int unsigned SOFT_RESET_NS = 400;
    localparam int unsigned SOFT_RESET_CYCLES =
        (SOFT_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Write precompensation delays in picoseconds.
    localparam int unsigned SHIFT_STEP_PS = 41670;
    localparam int unsigned SHIFT_DEFAULT_LOW_PS = 125000;
    localparam int unsigned SHIFT_DEFAULT_TOP_PS = 20800;
    localparam int unsigned SHIFT_PS_WIDTH = 18;

    // Bit rates in kbit/s per rate code, MFM and FM.
    localparam int unsigned RATE_KBPS_WIDTH = 11;
    localparam logic [10:0] MFM_KBPS_0 = 11'h1F4;
    localparam logic [10:0] MFM_KBPS_1 = 11'h12C;
    localparam logic [10:0] MFM_KBPS_2 = 11'h0FA;
    localparam logic [10:0] MFM_KBPS_3 = 11'h3E8;
    localparam logic [10:0] FM_KBPS_0 = 11'h0FA;
    localparam logic [10:0] FM_KBPS_1 = 11'h096;
    localparam logic [10:0] FM_KBPS_2 = 11'h07D;
    localparam logic [10:0] FM_KBPS_3 = 11'h000;

    // Steps allowed before a missing track-zero counts as an equipment fault.
    localparam int unsigned TRACK_ZERO_STEP_LIMIT = 77;

    // Command ending codes.
    localparam logic [1:0] END_NORMAL = 2'h0;
    localparam logic [1:0] END_ABNORMAL = 2'h1;
    localparam logic [1:0] END_INVALID = 2'h2;
    localparam logic [1:0] END_POLLING = 2'h3;

    // What the sequencer reports when a command ends.
    typedef struct packed {
        logic [1:0] termination_code;
        logic positioning_done;
        logic head_number;
        logic [1:0] unit_select_code;
    } frf_end_type;

    // Result status register zero as it leaves the data port.
    typedef struct packed {
        logic [1:0] termination_code;
        logic positioning_done;
        logic equipment_fault;
        logic drive_not_prepared;
        logic head_number;
        logic [1:0] unit_select_code;
    } frf_sr0_type;

    // A captured AHB address phase.
    typedef struct packed {
        logic write;
        logic read;
        logic mapped;
        logic [5:0] index;
    } frf_req_type;

    typedef enum logic {
        FRF_RUN,
        FRF_RESETTING
    } frf_state_type;

endpackage

// ### hdl/frf_floppy_regs.sv
/*
 * Register slice of a floppy controller: rate and control, main status, the byte-wide
 * command/result data port with its result stack, result status zero and an interrupt.
 * Assumes a single AHB-Lite master, a command sequencer on the same clock and
 * asynchronous drive pins that are synchronised here.
 */
// Chosen here: the AHB-Lite slave port.
// Summary of operation
// (RL1) Bit 7 resets controller, clears itself after.
// (RL2) Bit 6 enters low power, oscillator off.
// (RL3) Bits 4-2 select write precompensation delay.
// (RL4) Code 000 gives rate-dependent default delay.
// (RL5) Rate field resets to 10, encodes rates.
// (RL6) Commands, data and results use data port.
// (RL7) Four-entry result stack, one presented per access.
// (RL8) Data port buffer off until setup command.
// (RL9) Status zero bits 7-6 give ending.
// (RL10) Bit 5 set on positioning completion.
// (RL11) Bit 4 on fault or 77 steps.
// (RL12) Bit 3 reports drive not ready.
// (RL13) Bit 2 reports current head number.
// (RL14) Bits 1-0 report selected drive unit.
// (RL15) Reads at rate address return main status.
// (RL16) Status zero returned first in results.
`timescale 1ns/1ps
module frf_floppy_regs #(
    parameter int unsigned STACK_DEPTH = 4,
    parameter int unsigned STEP_LIMIT = frf_pkg::TRACK_ZERO_STEP_LIMIT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic [7:0] cmd_byte,
    output logic cmd_byte_valid,
    input wire logic [7:0] result_byte,
    input wire logic result_push,
    output logic result_ready,
    input wire logic command_end,
    input wire frf_pkg::frf_end_type end_info,
    input wire logic setup_command,
    input wire logic non_dma_mode,
    input wire logic controller_busy,
    input wire logic drive0_busy,
    input wire logic step_pulse,
    input wire logic recal_active,
    input wire logic fm_mode,
    input wire logic track_zero_input_n,
    input wire logic drive_fault,
    input wire logic drive_ready,
    output logic software_reset_pulse,
    output logic low_power_request,
    output logic osc_enable,
    output logic [17:0] write_shift_delay_ps,
    output logic [10:0] bit_rate_kbps,
    output logic fifo_enabled
);

    localparam int unsigned PTR_W = $clog2(STACK_DEPTH);
    localparam int unsigned CNT_W = PTR_W + 1;
    localparam int unsigned STEP_W = $clog2(STEP_LIMIT + 1);
    localparam int unsigned SRST_W = $clog2(frf_pkg::SOFT_RESET_CYCLES + 1);
    localparam int SRST_CY = frf_pkg::SOFT_RESET_CYCLES;
    localparam int unsigned IW = frf_pkg::IRQ_WIDTH;

    // Refuse a stack that the pointer arithmetic cannot wrap and a zero step limit.
    initial begin
        if (STACK_DEPTH < 2 || (1 << PTR_W) != STACK_DEPTH) begin
            $error("STACK_DEPTH must be a power of two of at least 2");
        end
        if (STEP_LIMIT < 1) begin
            $error("STEP_LIMIT must be at least 1");
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    frf_pkg::frf_state_type state_q, state_d;
    frf_pkg::frf_req_type req_q;
    logic [SRST_W-1:0] srst_cnt_q;
    logic [2:0] shift_q;
    logic [1:0] rate_q;
    logic low_power_q;
    logic [IW-1:0] irq_status_q, irq_mask_q;
    logic [7:0] stack_q [STACK_DEPTH];
    logic [PTR_W-1:0] rd_ptr_q, wr_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [2:0] sync1_q, sync2_q;
    logic [STEP_W-1:0] step_cnt_q;
    logic ec_q;
    logic fifo_en_q;
    logic [31:0] hrdata_q;
    logic [7:0] cmd_byte_q;
    logic cmd_valid_q;
    logic [17:0] delay_q;
    logic [10:0] kbps_q;

    // Address phase decode; the slave never inserts wait states.
    wire take = hsel && hready && htrans[1];
    wire [5:0] addr_index = haddr[7:2];
    wire idx_rate = addr_index == 6'(frf_pkg::RATE_CTRL_INDEX);
    wire idx_data = addr_index == 6'(frf_pkg::DATA_PORT_INDEX);
    wire idx_irqs = addr_index == 6'(frf_pkg::IRQ_STATUS_INDEX);
    wire idx_mask = addr_index == 6'(frf_pkg::IRQ_MASK_INDEX);
    wire addr_mapped = haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0 &&
        (idx_rate || idx_data || idx_irqs || idx_mask);
    wire rd_take = take && !hwrite && addr_mapped;

    // Data phase write strobes.
    wire wr_phase = req_q.write && req_q.mapped;
    wire wr_rate = wr_phase && req_q.index == 6'(frf_pkg::RATE_CTRL_INDEX);
    wire wr_data = wr_phase && req_q.index == 6'(frf_pkg::DATA_PORT_INDEX);
    wire wr_irqs = wr_phase && req_q.index == 6'(frf_pkg::IRQ_STATUS_INDEX);
    wire wr_mask = wr_phase && req_q.index == 6'(frf_pkg::IRQ_MASK_INDEX);
    wire [7:0] wbyte = hwdata[7:0];
    wire running = state_q == frf_pkg::FRF_RUN;
    wire srst_req = wr_rate && wbyte[frf_pkg::SOFT_RESET_BIT];

    // Synchronised drive pins: bit 0 track zero (low active), 1 fault, 2 ready.
    wire track_zero_s = !sync2_q[0];
    wire fault_s = sync2_q[1];
    wire ready_s = sync2_q[2];

    // Track-zero watchdog during recalibration.
    wire steps_exhausted = step_cnt_q == STEP_W'(STEP_LIMIT);
    wire ec_now = fault_s || steps_exhausted;

    // Result status zero assembled from the sequencer's ending report, the equipment fault and the drive ready pin.
    frf_pkg::frf_sr0_type sr0;
    assign sr0.termination_code = end_info.termination_code; // see (RL9)
    assign sr0.positioning_done = end_info.positioning_done; // see (RL10)
    assign sr0.equipment_fault = ec_q || ec_now; // see (RL11)
    assign sr0.drive_not_prepared = !ready_s; // see (RL12)
    assign sr0.head_number = end_info.head_number; // see (RL13)
    assign sr0.unit_select_code = end_info.unit_select_code; // see (RL14)

    // Result stack control; status zero enters on command_end, while result_ready is held low for other result bytes.
    wire stack_full = count_q == CNT_W'(STACK_DEPTH);
    wire stack_empty = count_q == '0;
    wire push_sr0 = command_end && running && !stack_full; // see (RL16)
    wire push_res = result_push && result_ready;
    wire push = push_sr0 || push_res;
    wire [7:0] push_byte = push_sr0 ? sr0 : result_byte;
    wire pop = rd_take && idx_data && !stack_empty && running; // see (RL7)
    wire [7:0] pop_byte = stack_empty ? 8'h00 : stack_q[rd_ptr_q];
    assign result_ready = running && !stack_full && !command_end;

    // Main status: request, direction, mode, busy and drive 0 busy.
    wire [7:0] main_status = {running, !stack_empty, non_dma_mode, controller_busy,
        3'h0, drive0_busy};

    // Read data selection at the address phase.
    wire [31:0] read_word =
        !addr_mapped ? 32'h00000000 :
        idx_rate ? {24'h000000, main_status} : // see (RL15)
        idx_data ? {24'h000000, pop_byte} : // see (RL6)
        idx_irqs ? {{(32 - IW){1'b0}}, irq_status_q} :
        {{(32 - IW){1'b0}}, irq_mask_q};

    // Interrupt events and their sticky status; a set beats a same-cycle clear.
    wire bad_rate = fm_mode && rate_q == frf_pkg::RATE_TOP_CODE;
    wire reset_done = !running && srst_cnt_q == '0;
    logic [IW-1:0] irq_event;
    assign irq_event[frf_pkg::IRQ_RESULT_BIT] = push_sr0;
    assign irq_event[frf_pkg::IRQ_BAD_RATE_BIT] = bad_rate;
    assign irq_event[frf_pkg::IRQ_RESET_DONE_BIT] = reset_done;
    wire [IW-1:0] irq_clear = wr_irqs ? hwdata[IW-1:0] : '0;
    wire [IW-1:0] irq_status_d = irq_event | (irq_status_q & ~irq_clear);
    assign irq = |(irq_status_q & irq_mask_q);

    // Precompensation delay and bit rate from the rate and control fields.
    wire [17:0] shift_default = rate_q == frf_pkg::RATE_TOP_CODE ?
        18'(frf_pkg::SHIFT_DEFAULT_TOP_PS) : 18'(frf_pkg::SHIFT_DEFAULT_LOW_PS);
    wire [17:0] shift_steps = 18'(shift_q * frf_pkg::SHIFT_STEP_PS);
    wire [17:0] delay_d =
        shift_q == frf_pkg::SHIFT_DEFAULT_CODE ? shift_default : // see (RL4)
        shift_q == frf_pkg::SHIFT_OFF_CODE ? 18'h00000 : shift_steps; // see (RL3)
    wire [10:0] mfm_kbps =
        rate_q == 2'h0 ? frf_pkg::MFM_KBPS_0 :
        rate_q == 2'h1 ? frf_pkg::MFM_KBPS_1 :
        rate_q == 2'h2 ? frf_pkg::MFM_KBPS_2 : frf_pkg::MFM_KBPS_3;
    wire [10:0] fm_kbps =
        rate_q == 2'h0 ? frf_pkg::FM_KBPS_0 :
        rate_q == 2'h1 ? frf_pkg::FM_KBPS_1 :
        rate_q == 2'h2 ? frf_pkg::FM_KBPS_2 : frf_pkg::FM_KBPS_3;
    wire [10:0] kbps_d = fm_mode ? fm_kbps : mfm_kbps; // see (RL5)

    // Soft reset sequencer state.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            frf_pkg::FRF_RUN: begin
                if (srst_req) begin
                    state_d = frf_pkg::FRF_RESETTING; // see (RL1)
                end
            end
            frf_pkg::FRF_RESETTING: begin
                if (srst_cnt_q == '0) begin
                    state_d = frf_pkg::FRF_RUN; // see (RL1)
                end
            end
        endcase
    end

    // Sequencer state and reset length counter.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= frf_pkg::FRF_RUN;
            srst_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (running && srst_req) begin
                srst_cnt_q <= SRST_W'(frf_pkg::SOFT_RESET_CYCLES - 1);
            end else if (srst_cnt_q != '0) begin
                srst_cnt_q <= srst_cnt_q - 1'b1;
            end
        end
    end

    // Bus side: capture address phase, register read data and the written fields.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
            hrdata_q <= 32'h00000000;
            shift_q <= frf_pkg::SHIFT_RESET;
            rate_q <= frf_pkg::RATE_RESET;
            low_power_q <= frf_pkg::LOW_POWER_RESET;
            irq_mask_q <= '0;
            irq_status_q <= '0;
        end else begin
            req_q <= '{write: take && hwrite, read: take && !hwrite,
                mapped: addr_mapped, index: addr_index};
            if (rd_take) begin
                hrdata_q <= read_word;
            end
            if (wr_rate) begin
                low_power_q <= wbyte[frf_pkg::LOW_POWER_BIT]; // see (RL2)
                shift_q <= wbyte[frf_pkg::SHIFT_LSB +: 3]; // see (RL3)
                rate_q <= wbyte[frf_pkg::RATE_LSB +: 2]; // see (RL5)
            end
            if (wr_mask) begin
                irq_mask_q <= hwdata[IW-1:0];
            end
            irq_status_q <= irq_status_d;
        end
    end

    // Pin synchronisers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
        end else begin
            sync1_q <= {drive_ready, drive_fault, track_zero_input_n};
            sync2_q <= sync1_q;
        end
    end

    // Step watchdog and latched equipment fault, held until the command ends.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_cnt_q <= '0;
            ec_q <= 1'b0;
        end else if (!running) begin
            step_cnt_q <= '0;
            ec_q <= 1'b0;
        end else begin
            if (!recal_active || track_zero_s) begin
                step_cnt_q <= '0;
            end else if (step_pulse && !steps_exhausted) begin
                step_cnt_q <= step_cnt_q + 1'b1; // see (RL11)
            end
            ec_q <= ec_now || (ec_q && !command_end);
        end
    end

    // Stack entries, one write port per entry.
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                stack_q[i] <= 8'h00;
            end else if (push && wr_ptr_q == PTR_W'(i)) begin
                stack_q[i] <= push_byte;
            end
        end
    end

    // Stack pointers, buffer enable and outgoing command bytes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            count_q <= '0;
            fifo_en_q <= 1'b0;
            cmd_byte_q <= 8'h00;
            cmd_valid_q <= 1'b0;
        end else if (!running) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            count_q <= '0;
            fifo_en_q <= 1'b0; // see (RL8)
            cmd_valid_q <= 1'b0;
        end else begin
            rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
            wr_ptr_q <= wr_ptr_q + PTR_W'(push);
            count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
            fifo_en_q <= fifo_en_q || setup_command; // see (RL8)
            cmd_valid_q <= wr_data; // see (RL6)
            if (wr_data) begin
                cmd_byte_q <= wbyte;
            end
        end
    end

    // Registered rate outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_q <= 18'(frf_pkg::SHIFT_DEFAULT_LOW_PS);
            kbps_q <= frf_pkg::MFM_KBPS_2;
        end else begin
            delay_q <= delay_d;
            kbps_q <= kbps_d;
        end
    end

    // Output drive.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign cmd_byte = cmd_byte_q;
    assign cmd_byte_valid = cmd_valid_q;
    assign software_reset_pulse = !running; // see (RL1)
    assign low_power_request = low_power_q; // see (RL2)
    assign osc_enable = !low_power_q; // see (RL2)
    assign write_shift_delay_ps = delay_q;
    assign bit_rate_kbps = kbps_q;
    assign fifo_enabled = fifo_en_q;

    // Checks guarding the documented behaviour.
    srst_clear_a: assert property ($rose(software_reset_pulse) |-> // see (RL1)
        ##SRST_CY !software_reset_pulse)
        else $error("soft reset did not clear itself in time");
    low_power_a: assert property (wr_rate && wbyte[frf_pkg::LOW_POWER_BIT] |=> // see (RL2)
        low_power_request && !osc_enable)
        else $error("low power write did not stop the oscillator");
    shift_step_a: assert property (shift_q inside {[3'h1:3'h6]} && $stable(shift_q) |=> // see (RL3)
        write_shift_delay_ps == 18'($past(shift_q) * frf_pkg::SHIFT_STEP_PS))
        else $error("write shift step delay wrong");
    shift_default_a: assert property (shift_q == 3'h0 && rate_q != 2'h3 |=> // see (RL4)
        write_shift_delay_ps == 18'(frf_pkg::SHIFT_DEFAULT_LOW_PS))
        else $error("default precompensation wrong");
    rate_fm_a: assert property (fm_mode && rate_q == 2'h2 |=> // see (RL5)
        bit_rate_kbps == frf_pkg::FM_KBPS_2)
        else $error("fm rate code 10 wrong");
    data_port_a: assert property (wr_data && running |=> // see (RL6)
        cmd_byte_valid && cmd_byte == $past(wbyte))
        else $error("data port write not forwarded");
    stack_bound_a: assert property (count_q <= CNT_W'(STACK_DEPTH) and // see (RL7)
        (pop |=> count_q == $past(count_q) - 1'b1 + CNT_W'($past(push))))
        else $error("result stack count wrong");
    fifo_off_a: assert property ($rose(software_reset_pulse) |=> !fifo_enabled) // see (RL8)
        else $error("buffer not disabled by reset");
    sr0_first_a: assert property (push_sr0 && stack_empty && !pop |=> // see (RL16)
        stack_q[rd_ptr_q][7:6] == $past(end_info.termination_code))
        else $error("status zero not first in results");
    steps_fault_a: assert property (steps_exhausted && running |=> ec_q) // see (RL11)
        else $error("missing track zero not reported");
    status_read_a: assert property (rd_take && idx_rate |=> // see (RL15)
        hrdata[7:0] == $past(main_status))
        else $error("main status not returned at rate address");

endmodule

// ### tb/frf_drive_model.sv
/*
 * Behavioural model of the command sequencer and floppy drive beside the register slice.
 * Assumes the bench calls its tasks right after a rising edge of hclk.
 */
`timescale 1ns/1ps
module frf_drive_model (
    input wire logic hclk,
    input wire logic result_ready,
    output logic command_end,
    output frf_pkg::frf_end_type end_info,
    output logic [7:0] result_byte,
    output logic result_push,
    output logic step_pulse,
    output logic recal_active,
    output logic track_zero_input_n,
    output logic drive_fault,
    output logic drive_ready
);
    // Idle levels at time zero; the drive starts ready with no fault.
    initial begin
        command_end = 1'b0;
        end_info = '0;
        result_byte = 8'h00;
        result_push = 1'b0;
        step_pulse = 1'b0;
        recal_active = 1'b0;
        track_zero_input_n = 1'b1;
        drive_fault = 1'b0;
        drive_ready = 1'b1;
    end

    // Ends a command for one cycle; the report lines are inverted once released.
    task automatic end_cmd(input frf_pkg::frf_end_type info);
        @(posedge hclk);
        end_info <= info;
        command_end <= 1'b1;
        @(posedge hclk);
        command_end <= 1'b0;
        end_info <= ~info;
    endtask

    // Pushes one result byte after the status byte and holds it until it is taken.
    task automatic push_byte(input logic [7:0] b);
        @(posedge hclk);
        result_byte <= b;
        result_push <= 1'b1;
        do @(posedge hclk); while (result_ready !== 1'b1);
        result_push <= 1'b0;
        result_byte <= ~b;
    endtask

    // Issues step pulses while recalibrating with track zero never found.
    task automatic step(input int n);
        recal_active <= 1'b1;
        repeat (n) begin
            @(posedge hclk);
            step_pulse <= 1'b1;
            @(posedge hclk);
            step_pulse <= 1'b0;
        end
        @(posedge hclk);
        recal_active <= 1'b0;
    endtask

    // Changes the drive pins and lets the synchronisers settle.
    task automatic set_pins(input logic rdy, input logic flt);
        drive_ready <= rdy;
        drive_fault <= flt;
        repeat (4) @(posedge hclk);
    endtask
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench of the floppy register slice with its drive model.
 * Assumes one AHB-Lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, hreadyout, hresp, irq, cmd_byte_valid, result_push, result_ready;
    logic command_end, setup_command = 1'b0, non_dma_mode = 1'b0, controller_busy = 1'b0;
    logic drive0_busy = 1'b0, step_pulse, recal_active, fm_mode = 1'b0, trk_n, fault, ready;
    logic sw_rst, low_pwr, osc_en, fifo_en;
    logic [7:0] cmd_byte, result_byte, v, seen_cmd;
    logic [17:0] delay_ps;
    logic [10:0] kbps;
    frf_pkg::frf_end_type info, end_info;
    int errors = 0, comparisons = 0, cyc = 0, n;

    always #20 hclk = ~hclk;

    frf_floppy_regs #(.STEP_LIMIT(3)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .cmd_byte(cmd_byte), .cmd_byte_valid(cmd_byte_valid),
        .result_byte(result_byte), .result_push(result_push), .result_ready(result_ready),
        .command_end(command_end), .end_info(end_info), .setup_command(setup_command),
        .non_dma_mode(non_dma_mode), .controller_busy(controller_busy),
        .drive0_busy(drive0_busy), .step_pulse(step_pulse), .recal_active(recal_active),
        .fm_mode(fm_mode), .track_zero_input_n(trk_n), .drive_fault(fault),
        .drive_ready(ready), .software_reset_pulse(sw_rst), .low_power_request(low_pwr),
        .osc_enable(osc_en), .write_shift_delay_ps(delay_ps), .bit_rate_kbps(kbps),
        .fifo_enabled(fifo_en));

    frf_drive_model drv_u (.hclk(hclk), .result_ready(result_ready),
        .command_end(command_end), .end_info(end_info), .result_byte(result_byte),
        .result_push(result_push), .step_pulse(step_pulse), .recal_active(recal_active),
        .track_zero_input_n(trk_n), .drive_fault(fault), .drive_ready(ready));

    // Keeps the last byte that the data port handed to the sequencer.
    always @(posedge hclk) if (cmd_byte_valid === 1'b1) seen_cmd <= cmd_byte;

    // Cuts a hang short.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer; both phases wait for hready.
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [10:0] exp_kbps(input logic [1:0] r, input logic fm);
        logic [10:0] t [4] = '{11'h1F4, 11'h12C, 11'h0FA, 11'h3E8};
        return fm ? (r == 2'h3 ? 11'h000 : t[r] >> 1) : t[r];
    endfunction

    function automatic logic [17:0] exp_delay(input logic [2:0] s, input logic [1:0] r);
        if (s == 3'h7) return 18'h00000;
        if (s == 3'h0) return (r == 2'h3) ? 18'h05140 : 18'h1E848;
        return 18'(s * 18'h0A2C6);
    endfunction

    function automatic logic [7:0] exp_sr0(input frf_pkg::frf_end_type i, input logic f,
        input logic r);
        return {i.termination_code, i.positioning_done, f, ~r, i.head_number,
            i.unit_select_code};
    endfunction

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence: reset, rate/control, main status, results, faults, soft reset.
    initial begin
        void'($urandom(49849));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(kbps, 11'h0FA);
        chk(delay_ps, 18'h1E848);
        chk({hresp, fifo_en, low_pwr, osc_en}, 4'h1);
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 8'h03 : (i == 1) ? 8'h1D : 8'($urandom) & 8'h5F;
            fm_mode <= 1'($urandom);
            bus(32'h10, 1'b1, {24'h0, v});
            repeat (3) @(posedge hclk);
            chk(kbps, exp_kbps(v[1:0], fm_mode));
            chk(delay_ps, exp_delay(v[4:2], v[1:0]));
            chk({low_pwr, osc_en}, {v[6], ~v[6]});
        end
        fm_mode <= 1'b0;
        bus(32'h10, 1'b1, 32'h02);
        non_dma_mode <= 1'($urandom);
        controller_busy <= 1'($urandom);
        drive0_busy <= 1'($urandom);
        bus(32'h20, 1'b1, 32'h07);
        bus(32'h24, 1'b1, 32'h01);
        bus(32'h10, 1'b0, 32'h0);
        chk(rd, {24'h0, 2'h2, non_dma_mode, controller_busy, 3'h0, drive0_busy});
        v = 8'($urandom);
        bus(32'h14, 1'b1, {24'h0, v});
        repeat (3) @(posedge hclk);
        chk(seen_cmd, v);
        info = 6'($urandom);
        drv_u.end_cmd(info);
        @(posedge hclk);
        chk(irq, 1'b1);
        for (n = 0; n < 3; n++) drv_u.push_byte(8'hA0 + 8'(n));
        @(negedge hclk);
        chk(result_ready, 1'b0);
        bus(32'h10, 1'b0, 32'h0);
        chk(rd[6], 1'b1);
        bus(32'h14, 1'b0, 32'h0);
        chk(rd, {24'h0, exp_sr0(info, 1'b0, 1'b1)});
        for (n = 0; n < 3; n++) begin
            bus(32'h14, 1'b0, 32'h0);
            chk(rd, 32'hA0 + 32'(n));
        end
        bus(32'h14, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(32'h20, 1'b1, 32'h01);
        @(posedge hclk);
        chk(irq, 1'b0);
        for (n = 0; n < 4; n++) begin
            drv_u.set_pins(n[0], n[1]);
            info = {2'(n), 4'($urandom)};
            drv_u.end_cmd(info);
            bus(32'h14, 1'b0, 32'h0);
            chk(rd, {24'h0, exp_sr0(info, n[1], n[0])});
        end
        drv_u.set_pins(1'b1, 1'b0);
        info = 6'($urandom);
        drv_u.end_cmd(info);
        bus(32'h14, 1'b0, 32'h0);
        drv_u.step(3);
        drv_u.end_cmd(info);
        bus(32'h14, 1'b0, 32'h0);
        chk(rd, {24'h0, exp_sr0(info, 1'b1, 1'b1)});
        setup_command <= 1'b1;
        @(posedge hclk);
        setup_command <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(fifo_en, 1'b1);
        bus(32'h24, 1'b1, 32'h04);
        bus(32'h10, 1'b1, 32'h82);
        for (n = 0; n < 20 && sw_rst !== 1'b1; n++) @(posedge hclk);
        for (n = 0; n < 40 && sw_rst === 1'b1; n++) @(posedge hclk);
        chk(n, 10);
        repeat (2) @(posedge hclk);
        chk({fifo_en, irq}, 2'h1);
        bus(32'h10, 1'b0, 32'h0);
        chk(rd[7], 1'b1);
        tally_and_finish();
    end
endmodule
